/* File: rtl/bise_pkg.sv */
package bise_pkg;

  localparam int unsigned DATA_W   = 8;
  localparam int unsigned PC_W     = 15;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned LATCH_W  = 7;

  // register byte offsets on the apb side
  localparam logic [7:0] ADDR_INSTR   = 8'h00;
  localparam logic [7:0] ADDR_ACCUM   = 8'h04;
  localparam logic [7:0] ADDR_FILE    = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0c;
  localparam logic [7:0] ADDR_PCLATCH = 8'h10;
  localparam logic [7:0] ADDR_PC      = 8'h14;
  localparam logic [7:0] ADDR_CYCLES  = 8'h18;

  // status register field positions
  localparam int unsigned STAT_ZERO_BIT  = 0;
  localparam int unsigned STAT_CARRY_BIT = 1;
  localparam int unsigned STAT_BUSY_BIT  = 2;

  // cycle report register field positions
  localparam int unsigned CYC_COUNT_LSB = 0;
  localparam int unsigned CYC_COUNT_MSB = 1;
  localparam int unsigned CYC_SKIP_BIT  = 4;

  // bits of the high latch that feed the program counter top
  localparam int unsigned LATCH_SEL_LSB = 3;
  localparam int unsigned LATCH_SEL_MSB = 6;

  localparam logic [DATA_W-1:0]  ACCUM_RST = 8'h00;
  localparam logic [DATA_W-1:0]  FILE_RST  = 8'h00;
  localparam logic [LATCH_W-1:0] LATCH_RST = 7'h00;
  localparam logic [PC_W-1:0]    PC_RST    = 15'h0000;
  localparam logic [PC_W-1:0]    PC_STEP   = 15'h0001;
  localparam logic [DATA_W-1:0]  INC_STEP  = 8'h01;

  localparam logic [1:0] CYC_NONE   = 2'h0;
  localparam logic [1:0] CYC_SINGLE = 2'h1;
  localparam logic [1:0] CYC_DOUBLE = 2'h2;

  localparam logic DEST_ACCUM = 1'b0;
  localparam logic DEST_FILE  = 1'b1;

  typedef enum logic [2:0] {
    op_jump_absolute      = 3'h0,
    op_increment_file     = 3'h1,
    op_increment_skip_zero = 3'h2,
    op_or_literal_accum   = 3'h3,
    op_or_accum_file      = 3'h4,
    op_shift_left_file    = 3'h5,
    op_nop                = 3'h7
  } bise_op_t;

  // instruction word as written to the instruction register
  typedef struct packed {
    logic [12:0] rsvd_hi;
    logic [10:0] operand;
    logic [3:0]  rsvd_lo;
    logic        dest;
    bise_op_t    op;
  } bise_instr_t;

  typedef struct packed {
    logic carry;
    logic zero;
  } bise_flags_t;

  typedef enum logic [2:0] {
    st_idle   = 3'b001,
    st_exec   = 3'b010,
    st_second = 3'b100
  } bise_state_t;

endpackage

/* File: rtl/bise_alu.sv */
module bise_alu
  import bise_pkg::*;
(
  input  wire bise_op_t          op_i,
  input  wire logic [DATA_W-1:0] accum_i,
  input  wire logic [DATA_W-1:0] file_i,
  input  wire logic [DATA_W-1:0] literal_i,
  output logic      [DATA_W-1:0] result_o,
  output logic                   carry_o,
  output logic                   zero_o
);

  wire [DATA_W-1:0] inc_res = 8'(file_i + INC_STEP);
  wire [DATA_W-1:0] orl_res = accum_i | literal_i;
  wire [DATA_W-1:0] orf_res = accum_i | file_i;
  wire [DATA_W-1:0] lsl_res = {file_i[6:0], 1'b0};

  assign result_o =
    (op_i == op_increment_file)      ? inc_res :
    (op_i == op_increment_skip_zero) ? inc_res :
    (op_i == op_or_literal_accum)    ? orl_res :
    (op_i == op_or_accum_file)       ? orf_res :
    (op_i == op_shift_left_file)     ? lsl_res :
                                       file_i;

  // carry only meaningful for the left shift
  assign carry_o = file_i[7];
  assign zero_o  = (result_o == 8'h00);

endmodule

/* File: rtl/bise_core.sv */
// Local design decisions: the APB interface to the registers and the address map.
module bise_core
  import bise_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              reset_i,
  input  wire logic              ce_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic                   pready_o,
  output logic                   pslverr_o,
  output logic      [31:0]       prdata_o
);

  bise_state_t       state;
  bise_state_t       next_state;
  bise_instr_t       ir;
  bise_flags_t       flags;
  logic [DATA_W-1:0] accum;
  logic [DATA_W-1:0] file_reg;
  logic [LATCH_W-1:0] pc_high_latch;
  logic [PC_W-1:0]   pc;
  logic [1:0]        last_cycles;
  logic              last_skip;
  logic              skip_active;
  logic              rdy_q;
  logic              err_q;
  logic [31:0]       rdata_q;

  logic [DATA_W-1:0] alu_result;
  logic              alu_carry;
  logic              alu_zero;

  // ---------------- apb decode ----------------
  wire busy       = (state != st_idle);
  wire hit_instr  = (paddr_i == ADDR_INSTR);
  wire hit_accum  = (paddr_i == ADDR_ACCUM);
  wire hit_file   = (paddr_i == ADDR_FILE);
  wire hit_status = (paddr_i == ADDR_STATUS);
  wire hit_latch  = (paddr_i == ADDR_PCLATCH);
  wire hit_pc     = (paddr_i == ADDR_PC);
  wire hit_cycles = (paddr_i == ADDR_CYCLES);
  wire hit_any    = hit_instr | hit_accum | hit_file | hit_status
                  | hit_latch | hit_pc | hit_cycles;
  // pc and cycle report are read-only, instruction is write-only
  wire bad_access = ~hit_any | (pwrite_i & (hit_pc | hit_cycles));

  // accesses stall while an instruction runs, so software never
  // observes a half-updated accumulator or file value
  wire acc_start  = ce_i & psel_i & penable_i & ~busy & ~rdy_q;
  wire acc_done   = ce_i & psel_i & penable_i & rdy_q;
  wire wr_done    = acc_done & pwrite_i & ~err_q;

  wire wr_instr   = wr_done & hit_instr;
  wire wr_accum   = wr_done & hit_accum;
  wire wr_file    = wr_done & hit_file;
  wire wr_status  = wr_done & hit_status;
  wire wr_latch   = wr_done & hit_latch;

  wire [31:0] status_word = {29'h0, busy, flags.carry, flags.zero};
  wire [31:0] cycles_word = {27'h0, last_skip, 2'h0, last_cycles};

  wire [31:0] rd_mux =
    hit_accum  ? {24'h0, accum}           :
    hit_file   ? {24'h0, file_reg}        :
    hit_status ? status_word              :
    hit_latch  ? {25'h0, pc_high_latch}   :
    hit_pc     ? {17'h0, pc}              :
    hit_cycles ? cycles_word              :
                 32'h0000_0000;

  assign pready_o  = rdy_q;
  assign pslverr_o = rdy_q & err_q;
  assign prdata_o  = rdata_q;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdy_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (ce_i) begin
      rdy_q   <= acc_start;
      if (acc_start) begin
        err_q   <= bad_access;
        rdata_q <= (pwrite_i | bad_access) ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // ---------------- execute ----------------
  bise_alu u_alu (
    .op_i      (ir.op),
    .accum_i   (accum),
    .file_i    (file_reg),
    .literal_i (ir.operand[7:0]),
    .result_o  (alu_result),
    .carry_o   (alu_carry),
    .zero_o    (alu_zero)
  );

  wire ex_go     = ce_i & (state == st_exec);
  wire sec_go    = ce_i & (state == st_second);
  wire op_jump   = (ir.op == op_jump_absolute);
  wire op_inc    = (ir.op == op_increment_file);
  wire op_incsz  = (ir.op == op_increment_skip_zero);
  wire op_orl    = (ir.op == op_or_literal_accum);
  wire op_orf    = (ir.op == op_or_accum_file);
  wire op_lsl    = (ir.op == op_shift_left_file);
  wire op_fileop = op_inc | op_incsz | op_orf | op_lsl;
  wire skip_now  = op_incsz & alu_zero;
  wire two_cycle = op_jump | skip_now;

  wire to_file   = ex_go & op_fileop & (ir.dest == DEST_FILE);
  wire to_accum  = ex_go & ((op_fileop & (ir.dest == DEST_ACCUM))
                           | op_orl);
  wire z_update  = ex_go & (op_inc | op_orl | op_orf | op_lsl);
  wire c_update  = ex_go & op_lsl;

  wire [PC_W-1:0] jump_target =
    {pc_high_latch[LATCH_SEL_MSB:LATCH_SEL_LSB], ir.operand};

  always_comb begin
    next_state = state;
    case (state)
      st_idle:   next_state = wr_instr ? st_exec : st_idle;
      st_exec:   next_state = two_cycle ? st_second : st_idle;
      st_second: next_state = st_idle;
      default:   next_state = st_idle;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= st_idle;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ir <= '{rsvd_hi: 13'h0, operand: 11'h0, rsvd_lo: 4'h0,
              dest: DEST_ACCUM, op: op_nop};
    end else if (wr_instr) begin
      ir <= bise_instr_t'(pwdata_i);
    end
  end

  // hardware result wins over a software write in the same cycle
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      accum    <= ACCUM_RST;
      file_reg <= FILE_RST;
    end else if (ce_i) begin
      if (to_accum) begin
        accum <= alu_result;
      end else if (wr_accum) begin
        accum <= pwdata_i[DATA_W-1:0];
      end
      if (to_file) begin
        file_reg <= alu_result;
      end else if (wr_file) begin
        file_reg <= pwdata_i[DATA_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      flags <= '{carry: 1'b0, zero: 1'b0};
    end else if (ce_i) begin
      if (z_update) begin
        flags.zero <= alu_zero;
      end else if (wr_status) begin
        flags.zero <= pwdata_i[STAT_ZERO_BIT];
      end
      if (c_update) begin
        flags.carry <= alu_carry;
      end else if (wr_status) begin
        flags.carry <= pwdata_i[STAT_CARRY_BIT];
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pc_high_latch <= LATCH_RST;
    end else if (wr_latch) begin
      pc_high_latch <= pwdata_i[LATCH_W-1:0];
    end
  end

  // a skipped slot still advances the counter past the squashed word
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pc          <= PC_RST;
      skip_active <= 1'b0;
      last_cycles <= CYC_NONE;
      last_skip   <= 1'b0;
    end else if (ex_go) begin
      skip_active <= skip_now;
      last_skip   <= skip_now;
      last_cycles <= two_cycle ? CYC_DOUBLE : CYC_SINGLE;
      pc          <= op_jump ? jump_target : 15'(pc + PC_STEP);
    end else if (sec_go) begin
      skip_active <= 1'b0;
      if (skip_active) begin
        pc <= 15'(pc + PC_STEP);
      end
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  logic [DATA_W-1:0] dest_val;
  assign dest_val = (ir.dest == DEST_FILE) ? file_reg : accum;

  property p_jump_low;
    ex_go && op_jump |=> pc[10:0] == $past(ir.operand);
  endproperty
  a_jump_low: assert property (p_jump_low)
    else $error("jump low pc bits wrong");

  property p_jump_high;
    ex_go && op_jump |=>
      pc[14:11] == $past(pc_high_latch[LATCH_SEL_MSB:LATCH_SEL_LSB]);
  endproperty
  a_jump_high: assert property (p_jump_high)
    else $error("jump high pc bits wrong");

  property p_jump_two;
    ex_go && op_jump |=> state == st_second && $stable(flags)
      ##1 (!$past(ce_i) || state == st_idle);
  endproperty
  a_jump_two: assert property (p_jump_two)
    else $error("jump cycle count or flags wrong");

  property p_inc;
    ex_go && op_inc |=>
      dest_val == 8'($past(file_reg) + INC_STEP)
      && flags.zero == (dest_val == 8'h00);
  endproperty
  a_inc: assert property (p_inc)
    else $error("increment result or zero wrong");

  property p_incsz;
    ex_go && op_incsz |=> $stable(flags)
      && (state == st_second) == (dest_val == 8'h00);
  endproperty
  a_incsz: assert property (p_incsz)
    else $error("increment skip behaviour wrong");

  property p_dest_accum;
    ex_go && op_fileop && ir.dest == DEST_ACCUM |=> $stable(file_reg);
  endproperty
  a_dest_accum: assert property (p_dest_accum)
    else $error("file written with accumulator destination");

  property p_orl;
    ex_go && op_orl |=>
      accum == ($past(accum) | $past(ir.operand[7:0]))
      && flags.zero == (accum == 8'h00);
  endproperty
  a_orl: assert property (p_orl)
    else $error("literal or result wrong");

  property p_orf;
    ex_go && op_orf |=> dest_val == ($past(accum) | $past(file_reg))
      && flags.zero == (dest_val == 8'h00);
  endproperty
  a_orf: assert property (p_orf)
    else $error("file or result wrong");

  property p_lsl_carry;
    ex_go && op_lsl |=> flags.carry == $past(file_reg[7])
      && dest_val[7:1] == $past(file_reg[6:0]);
  endproperty
  a_lsl_carry: assert property (p_lsl_carry)
    else $error("left shift carry or bits wrong");

  property p_lsl_zero;
    ex_go && op_lsl |=> dest_val[0] == 1'b0
      && flags.zero == (dest_val == 8'h00);
  endproperty
  a_lsl_zero: assert property (p_lsl_zero)
    else $error("left shift low bit or zero wrong");

  property p_single;
    ex_go && !op_jump && !skip_now |=> state == st_idle;
  endproperty
  a_single: assert property (p_single)
    else $error("plain instruction not single cycle");

  property p_nop;
    ex_go && ir.op == op_nop |=> state == st_idle && $stable(accum)
      && $stable(file_reg) && $stable(flags);
  endproperty
  a_nop: assert property (p_nop)
    else $error("nop changed state or took two cycles");

  property p_skip_pc;
    sec_go && skip_active |=> pc == 15'($past(pc) + PC_STEP);
  endproperty
  a_skip_pc: assert property (p_skip_pc)
    else $error("squashed slot did not advance pc");

  property p_carry_keep;
    ex_go && !op_lsl |=> $stable(flags.carry);
  endproperty
  a_carry_keep: assert property (p_carry_keep)
    else $error("carry changed outside left shift");

  // a low enable must hold every piece of state, bus side included
  property p_freeze;
    !ce_i |=> $stable(state) && $stable(accum) && $stable(file_reg)
      && $stable(flags) && $stable(pc) && $stable(ir)
      && $stable(pc_high_latch) && $stable(rdy_q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while enable low");

  property p_ready_once;
    pready_o && ce_i |=> !pready_o;
  endproperty
  a_ready_once: assert property (p_ready_once)
    else $error("pready held longer than one cycle");

  c_jump:  cover property (ex_go && op_jump);
  c_skip:  cover property (ex_go && skip_now);
  c_lsl_c: cover property (ex_go && op_lsl && alu_carry);
  c_stall: cover property (psel_i && penable_i && busy);
  c_freeze: cover property (!ce_i && busy);

endmodule

/* File: verification/bise_tb.sv */
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
  fail_count++; $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
  end end

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import bise_pkg::*;

  logic              core_clk_i;
  logic              reset_i;
  logic              ce_i;
  logic              psel_i;
  logic              penable_i;
  logic              pwrite_i;
  logic [ADDR_W-1:0] paddr_i;
  logic [31:0]       pwdata_i;
  logic              pready_o;
  logic              pslverr_o;
  logic [31:0]       prdata_o;
  int                fail_count;
  int                n_tests;
  int                cyc;
  logic [31:0]       pc0;
  logic              hold_sel;
  logic              chained;

  bise_core bise_core_inst (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .ce_i       (ce_i),
    .psel_i     (psel_i),
    .penable_i  (penable_i),
    .pwrite_i   (pwrite_i),
    .paddr_i    (paddr_i),
    .pwdata_i   (pwdata_i),
    .pready_o   (pready_o),
    .pslverr_o  (pslverr_o),
    .prdata_o   (prdata_o)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // a hang anywhere ends up here; the full run needs well under 1000 cycles
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      end_sim();
    end
  end

  // request held until pready is seen at a rising edge; with hold_sel set
  // psel stays up and the next setup follows at once
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic eexp, output logic [31:0] r);
    int n;
    n = 0;
    if (!chained) begin
      @(posedge core_clk_i);
      penable_i <= 1'b0;
    end
    psel_i    <= 1'b1;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 100);
    r = prdata_o;
    `CHK("pready", 1'b1, pready_o)
    `CHK("pslverr", eexp, pslverr_o)
    penable_i <= 1'b0;
    if (!hold_sel) begin
      psel_i <= 1'b0;
    end
    chained = hold_sel;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    acc(1'b1, a, d, 1'b0, r);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] exp);
    logic [31:0] r;
    acc(1'b0, a, 32'h0, 1'b0, r);
    `CHK(nm, exp, r)
  endtask

  task automatic exec(input bise_op_t op, input logic dst,
                      input logic [10:0] k);
    wr(ADDR_INSTR, {13'h0, k, 4'h0, dst, op});
  endtask

  task automatic t_reset;
    logic [31:0] r;
    rdc("accum", ADDR_ACCUM, 32'h0);
    rdc("file", ADDR_FILE, 32'h0);
    rdc("status", ADDR_STATUS, 32'h0);
    rdc("latch", ADDR_PCLATCH, 32'h0);
    rdc("pc", ADDR_PC, 32'h0);
    rdc("instr", ADDR_INSTR, 32'h0);
    acc(1'b0, 8'h1c, 32'h0, 1'b1, r);
    `CHK("unmapped data", 32'h0, r)
    acc(1'b1, ADDR_PC, 32'h0000_1234, 1'b1, r);
    rdc("pc ro", ADDR_PC, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_jump;
    wr(ADDR_PCLATCH, 32'h5a);
    wr(ADDR_STATUS, 32'h3);
    exec(op_jump_absolute, DEST_ACCUM, 11'h5a5);
    rdc("pc", ADDR_PC, 32'h5da5);
    rdc("cycles", ADDR_CYCLES, 32'h2);
    rdc("status", ADDR_STATUS, 32'h3);
    // latch bits 4:3 clear but bit 6 set: only the 6:3 reading gives 4000
    wr(ADDR_PCLATCH, 32'h47);
    wr(ADDR_STATUS, 32'h0);
    exec(op_jump_absolute, DEST_FILE, 11'h000);
    rdc("pc", ADDR_PC, 32'h4000);
    rdc("status", ADDR_STATUS, 32'h0);
    $display("test jump done");
  endtask

  task automatic t_incr;
    wr(ADDR_STATUS, 32'h2);
    wr(ADDR_FILE, 32'hff);
    exec(op_increment_file, DEST_ACCUM, 11'h0);
    rdc("accum", ADDR_ACCUM, 32'h0);
    rdc("file", ADDR_FILE, 32'hff);
    rdc("status", ADDR_STATUS, 32'h3);
    rdc("cycles", ADDR_CYCLES, 32'h1);
    wr(ADDR_FILE, 32'h41);
    exec(op_increment_file, DEST_FILE, 11'h0);
    rdc("file", ADDR_FILE, 32'h42);
    rdc("accum", ADDR_ACCUM, 32'h0);
    rdc("status", ADDR_STATUS, 32'h2);
    $display("test increment done");
  endtask

  task automatic t_skip;
    wr(ADDR_STATUS, 32'h2);
    wr(ADDR_FILE, 32'hff);
    acc(1'b0, ADDR_PC, 32'h0, 1'b0, pc0);
    exec(op_increment_skip_zero, DEST_FILE, 11'h0);
    rdc("file", ADDR_FILE, 32'h0);
    rdc("status", ADDR_STATUS, 32'h2);
    rdc("cycles", ADDR_CYCLES, 32'h12);
    rdc("pc", ADDR_PC, pc0 + 32'h2);
    wr(ADDR_FILE, 32'h10);
    exec(op_increment_skip_zero, DEST_ACCUM, 11'h0);
    rdc("accum", ADDR_ACCUM, 32'h11);
    rdc("file", ADDR_FILE, 32'h10);
    rdc("cycles", ADDR_CYCLES, 32'h1);
    $display("test skip done");
  endtask

  task automatic t_or;
    wr(ADDR_ACCUM, 32'h0);
    wr(ADDR_STATUS, 32'h0);
    exec(op_or_literal_accum, DEST_ACCUM, 11'h000);
    rdc("status", ADDR_STATUS, 32'h1);
    // operand bits above the literal byte must not leak in
    wr(ADDR_ACCUM, 32'h12);
    exec(op_or_literal_accum, DEST_FILE, 11'h781);
    rdc("accum", ADDR_ACCUM, 32'h93);
    rdc("status", ADDR_STATUS, 32'h0);
    wr(ADDR_STATUS, 32'h1);
    wr(ADDR_ACCUM, 32'h0f);
    wr(ADDR_FILE, 32'hf0);
    exec(op_or_accum_file, DEST_FILE, 11'h0);
    rdc("file", ADDR_FILE, 32'hff);
    rdc("accum", ADDR_ACCUM, 32'h0f);
    rdc("status", ADDR_STATUS, 32'h0);
    wr(ADDR_ACCUM, 32'h21);
    wr(ADDR_FILE, 32'h84);
    exec(op_or_accum_file, DEST_ACCUM, 11'h0);
    rdc("accum", ADDR_ACCUM, 32'ha5);
    rdc("file", ADDR_FILE, 32'h84);
    $display("test or done");
  endtask

  task automatic t_shift;
    wr(ADDR_STATUS, 32'h0);
    wr(ADDR_FILE, 32'h81);
    exec(op_shift_left_file, DEST_ACCUM, 11'h0);
    rdc("accum", ADDR_ACCUM, 32'h02);
    rdc("file", ADDR_FILE, 32'h81);
    rdc("status", ADDR_STATUS, 32'h2);
    wr(ADDR_FILE, 32'h80);
    exec(op_shift_left_file, DEST_FILE, 11'h0);
    rdc("file", ADDR_FILE, 32'h0);
    rdc("status", ADDR_STATUS, 32'h3);
    wr(ADDR_FILE, 32'h40);
    exec(op_shift_left_file, DEST_FILE, 11'h0);
    rdc("file", ADDR_FILE, 32'h80);
    rdc("status", ADDR_STATUS, 32'h0);
    rdc("cycles", ADDR_CYCLES, 32'h1);
    $display("test shift done");
  endtask

  task automatic t_stall;
    wr(ADDR_PCLATCH, 32'h18);
    hold_sel = 1'b1;
    exec(op_jump_absolute, DEST_ACCUM, 11'h123);
    hold_sel = 1'b0;
    // set up while the jump still runs, so the access phase stalls
    rdc("pc stall", ADDR_PC, 32'h1923);
    acc(1'b0, ADDR_PC, 32'h0, 1'b0, pc0);
    exec(op_nop, DEST_FILE, 11'h7ff);
    rdc("pc nop", ADDR_PC, pc0 + 32'h1);
    rdc("cycles nop", ADDR_CYCLES, 32'h1);
    $display("test stall done");
  endtask

  task automatic t_freeze;
    logic [31:0] r;
    wr(ADDR_FILE, 32'h41);
    exec(op_increment_file, DEST_FILE, 11'h0);
    // enable drops while the increment waits in its execute cycle
    ce_i <= 1'b0;
    fork
      acc(1'b0, ADDR_FILE, 32'h0, 1'b0, r);
      begin
        repeat (6) begin
          @(posedge core_clk_i);
          `CHK("pready frozen", 1'b0, pready_o)
        end
        ce_i <= 1'b1;
      end
    join
    `CHK("file after freeze", 32'h42, r)
    $display("test freeze done");
  endtask

  initial begin
    reset_i    = 1'b1;
    ce_i       = 1'b1;
    psel_i     = 1'b0;
    penable_i  = 1'b0;
    pwrite_i   = 1'b0;
    paddr_i    = '0;
    pwdata_i   = '0;
    fail_count = 0;
    n_tests    = 0;
    cyc        = 0;
    hold_sel   = 1'b0;
    chained    = 1'b0;
    repeat (12) @(posedge core_clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_jump();
    t_incr();
    t_skip();
    t_or();
    t_shift();
    t_stall();
    t_freeze();
    end_sim();
  end
endmodule
